// ==== pec_defs.svh ====
// Register offsets, field positions, reset values and vectors.
`ifndef PEC_DEFS_SVH
`define PEC_DEFS_SVH
`define PEC_OFF_STATUS 8'h00
`define PEC_OFF_CAUSE 8'h04
`define PEC_OFF_EPC 8'h08
`define PEC_OFF_ERRPC 8'h0c
`define PEC_ST_IE_C 0
`define PEC_ST_KU_C 1
`define PEC_ST_MASK_LSB 8
`define PEC_ST_PE 16
`define PEC_ST_BEV 22
`define PEC_ST_WBE 23
`define PEC_CA_CODE_LSB 2
`define PEC_CA_PEND_LSB 8
`define PEC_CA_BD 31
`define PEC_STACK_RST 6'h00
`define PEC_MASK_RST 8'h00
`define PEC_BEV_RST 1'b1
`define PEC_FPU_INT_BIT 3
`define PEC_INSTR_BYTES 32'h0000_0004
`define PEC_VEC_RESET 32'hbfc0_0000
`define PEC_VEC_GEN 32'h8000_0180
`define PEC_VEC_GEN_BOOT 32'hbfc0_0180
`define PEC_VEC_REFILL 32'h8000_0000
`define PEC_VEC_REFILL_BOOT 32'hbfc0_0100
`define PEC_VEC_CERR 32'ha000_0100
`define PEC_VEC_CERR_BOOT 32'hbfc0_0300
`endif

// ==== pec_pkg.sv ====
// Types shared by the exception control block.
`default_nettype none
package pec_pkg;
  typedef enum logic [4:0] {
    PEC_C_INT = 5'h00,
    PEC_C_MOD = 5'h01,
    PEC_C_TLB = 5'h02,
    PEC_C_TLB_INV = 5'h03,
    PEC_C_ADDR = 5'h04,
    PEC_C_USEG = 5'h05,
    PEC_C_DBUS = 5'h07,
    PEC_C_SYS = 5'h08,
    PEC_C_BRK = 5'h09,
    PEC_C_RSVD = 5'h0a,
    PEC_C_CPU = 5'h0b,
    PEC_C_OVF = 5'h0c,
    PEC_C_TRAP = 5'h0d,
    PEC_C_BOUND = 5'h0e,
    PEC_C_WATCH = 5'h17,
    PEC_C_CACHE = 5'h1e,
    PEC_C_NMI = 5'h1f
  } pec_code_t;

  typedef struct packed {
    logic addr_err;
    logic user_seg;
    logic tlb_miss;
    logic tlb_refill;
    logic tlb_invalid;
    logic tlb_mod;
    logic bound;
    logic watch;
    logic bus_err_rd;
    logic illegal;
    logic cop_off;
    logic syscall;
    logic brk;
    logic trap;
    logic overflow;
    logic eret;
    logic rfe;
  } pec_event_t;

  typedef struct packed {
    logic valid;
    logic bd;
    logic eret;
    logic rfe;
    logic exc;
    logic refill;
    pec_code_t code;
    logic [31:0] pc;
  } pec_slot_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } pec_reg_req_t;
endpackage
`default_nettype wire

// ==== pec_stage.sv ====
// One pipeline stage carrying an instruction and its pending exception.
`timescale 1ns/1ps
`default_nettype none
module pec_stage (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Flow control.
  input wire logic adv,
  input wire logic kill,
  // Instruction in, faults seen here, instruction out.
  input wire pec_pkg::pec_slot_t slot_in,
  input wire pec_pkg::pec_event_t ev,
  output var pec_pkg::pec_slot_t slot_q
);
  import pec_pkg::*;

  pec_slot_t slot_nxt;
  logic fault;

  function automatic pec_code_t pick(input pec_event_t e);
    pec_code_t c;
    c = PEC_C_OVF;
    if (e.addr_err) c = PEC_C_ADDR;
    else if (e.user_seg) c = PEC_C_USEG;
    else if (e.tlb_miss) c = PEC_C_TLB;
    else if (e.tlb_invalid) c = PEC_C_TLB_INV;
    else if (e.tlb_mod) c = PEC_C_MOD;
    else if (e.bound) c = PEC_C_BOUND;
    else if (e.watch) c = PEC_C_WATCH;
    else if (e.bus_err_rd) c = PEC_C_DBUS;
    else if (e.illegal) c = PEC_C_RSVD;
    else if (e.cop_off) c = PEC_C_CPU;
    else if (e.syscall) c = PEC_C_SYS;
    else if (e.brk) c = PEC_C_BRK;
    else if (e.trap) c = PEC_C_TRAP;
    return c;
  endfunction

  // An older fault already carried keeps its code; later ones are dropped.
  always_comb begin
    slot_nxt = slot_in;
    fault = ev.addr_err | ev.user_seg | ev.tlb_miss | ev.tlb_invalid |
            ev.tlb_mod | ev.bound | ev.watch | ev.bus_err_rd |
            ev.illegal | ev.cop_off | ev.syscall | ev.brk | ev.trap |
            ev.overflow;
    if (slot_in.valid && !slot_in.exc && fault) begin
      slot_nxt.exc = 1'b1;
      slot_nxt.code = pick(ev);
      slot_nxt.refill = ev.tlb_miss & ev.tlb_refill;
    end
    slot_nxt.eret = slot_in.eret | (slot_in.valid & ev.eret);
    slot_nxt.rfe = slot_in.rfe | (slot_in.valid & ev.rfe);
  end

  always_ff @(posedge clk_sys) begin
    if (rst || kill) begin
      slot_q <= '0;
    end else if (adv) begin
      slot_q <= slot_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== pec_precise_exc_ctrl.sv ====
// Precise exception control: commit-stage ordering, redirect, registers.
// Function
// - All disruptive events share one exception entry mechanism.
// - All exceptions but user translation refill, cache error, NMI and soft reset go to one handler.
// - Only the resume address is saved, no general registers.
// - Only interrupts can be masked; other exceptions are always taken.
// - Per-source interrupt masks exist; no hardware interrupt priority.
// - Internal exception saves the faulting instruction address.
// - Delay-slot fault saves branch address and sets branch delay flag.
// - Cause shows exception code and pending external interrupts.
// - A write bus error never raises an exception.
// - Cache parity error sets parity flag, no exception.
// - Data translation miss seen in memory stage, instruction miss at fetch.
// - Early faults wait for older instructions; older fault wins.
// - Younger instructions are nullified with no visible effect.
// - Illegal, disabled coprocessor, overflow, misalign, user segment faults.
// - Invalid mapping, write-protect and missing translation faults.
// - Bound and watch hits on instruction or data raise exceptions.
// - Syscall, trap and breakpoint instructions always raise exceptions.
// - Float unit exceptions arrive as an interrupt source.
// - New return restores mode stack and jumps to saved address.
// - Old return only restores mode stack, no change of flow.
// - Entry pushes the three-entry mode stack, kernel with interrupts off.
// - Handler fetch starts at most one clock after faulting commit.
// - General vector is 0x80000180 with bootstrap vectors off.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pec_defs.svh"
module pec_precise_exc_ctrl (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Pipeline flow and fetched instruction.
  input wire logic pipe_adv,
  input wire logic if_valid,
  input wire logic [31:0] if_pc,
  input wire logic if_in_delay_slot,
  // Faults seen per stage: fetch, decode, execute, memory.
  input wire pec_pkg::pec_event_t stage_ev [4],
  // Interrupt and error sources.
  input wire logic [7:0] ext_int,
  input wire logic fpu_exc,
  input wire logic nmi,
  input wire logic soft_reset,
  input wire logic cache_err,
  input wire logic cache_parity_err,
  input wire logic bus_err_wr,
  // Register port.
  input wire pec_pkg::pec_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  // Fetch redirect and retirement.
  output logic redirect,
  output logic [31:0] redirect_pc,
  output logic retire,
  output logic [31:0] retire_pc,
  // Processor mode.
  output logic user_mode,
  output logic int_enable
);
  import pec_pkg::*;

  pec_slot_t slot_in [4];
  pec_slot_t slot_q [4];
  pec_slot_t c;
  logic [5:0] stack_r;
  logic [7:0] mask_r;
  logic bev_r;
  logic parity_r;
  logic wbe_r;
  logic bd_r;
  pec_code_t code_r;
  logic [31:0] epc_r;
  logic [31:0] errpc_r;
  logic errrst_pend_r;
  logic cache_pend_r;
  logic [7:0] pend;
  logic int_req;
  logic commit;
  logic no_err;
  logic t_err;
  logic t_cache;
  logic t_exc;
  logic t_int;
  logic t_eret;
  logic t_rfe;
  logic take;
  logic kill;
  logic [31:0] ret_pc;
  logic [31:0] vec;
  logic st_we;
  logic epc_we;
  logic errpc_we;
  logic [31:0] st_val;
  logic [31:0] ca_val;

  // Stage 0 takes the fetched instruction; later stages chain on.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_stage
      if (g == 0) begin : g_head
        assign slot_in[g] = {if_valid, if_in_delay_slot, 4'h0, PEC_C_INT,
                             if_pc};
      end else begin : g_link
        assign slot_in[g] = slot_q[g-1];
      end
      pec_stage u_stage (
        .clk_sys(clk_sys),
        .rst(rst),
        .adv(pipe_adv),
        .kill(kill),
        .slot_in(slot_in[g]),
        .ev(stage_ev[g]),
        .slot_q(slot_q[g])
      );
    end
  endgenerate

  assign c = slot_q[3];

  // Pending interrupts; the float unit shares source bit 3 with ext_int[3].
  always_comb begin
    pend = ext_int;
    pend[`PEC_FPU_INT_BIT] = ext_int[`PEC_FPU_INT_BIT] | fpu_exc;
  end

  // Any unmasked source requests while interrupts are enabled; no ordering among sources.
  assign int_req = stack_r[`PEC_ST_IE_C] & |(pend & mask_r);

  // Commit stage decision; everything funnels into one entry path.
  assign commit = pipe_adv & c.valid;
  assign no_err = ~errrst_pend_r & ~cache_pend_r;
  assign t_err = commit & errrst_pend_r;
  assign t_cache = commit & cache_pend_r & ~errrst_pend_r;
  assign t_exc = commit & no_err & c.exc;
  assign t_int = commit & no_err & ~c.exc & int_req;
  assign t_eret = commit & no_err & ~c.exc & ~int_req & c.eret;
  assign t_rfe = commit & no_err & ~c.exc & ~int_req & c.rfe;
  assign take = t_err | t_cache | t_exc | t_int;
  assign kill = take | t_eret;

  // Resume address backs up to the branch for a delay-slot instruction.
  assign ret_pc = c.bd ? c.pc - `PEC_INSTR_BYTES : c.pc;

  always_comb begin
    vec = bev_r ? `PEC_VEC_GEN_BOOT : `PEC_VEC_GEN;
    if (t_err) begin
      vec = `PEC_VEC_RESET;
    end else if (t_cache) begin
      vec = bev_r ? `PEC_VEC_CERR_BOOT : `PEC_VEC_CERR;
    end else if (t_exc && c.refill) begin
      vec = bev_r ? `PEC_VEC_REFILL_BOOT : `PEC_VEC_REFILL;
    end else if (t_eret) begin
      vec = epc_r;
    end
  end

  // Redirect is registered, so fetch moves one clock after commit.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      redirect <= 1'b0;
      redirect_pc <= 32'h0000_0000;
    end else begin
      redirect <= kill;
      if (kill) begin
        redirect_pc <= vec;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      retire <= 1'b0;
      retire_pc <= 32'h0000_0000;
    end else begin
      retire <= commit & ~take;
      if (commit) begin
        retire_pc <= c.pc;
      end
    end
  end

  // Error-class events wait for a commit; a new event beats the clear.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      errrst_pend_r <= 1'b0;
      cache_pend_r <= 1'b0;
    end else begin
      errrst_pend_r <= nmi | soft_reset | (errrst_pend_r & ~t_err);
      cache_pend_r <= cache_err | (cache_pend_r & ~t_cache);
    end
  end

  assign st_we = reg_req.we && reg_req.addr == `PEC_OFF_STATUS;
  assign epc_we = reg_req.we && reg_req.addr == `PEC_OFF_EPC;
  assign errpc_we = reg_req.we && reg_req.addr == `PEC_OFF_ERRPC;

  // Mode stack: push on entry, pop on either return.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stack_r <= `PEC_STACK_RST;
    end else if (take) begin
      stack_r <= {stack_r[3:0], 2'b00};
    end else if (t_eret || t_rfe) begin
      stack_r <= {stack_r[5:4], stack_r[5:2]};
    end else if (st_we) begin
      stack_r <= reg_req.wdata[5:0];
    end
  end

  assign user_mode = stack_r[`PEC_ST_KU_C];
  assign int_enable = stack_r[`PEC_ST_IE_C];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask_r <= `PEC_MASK_RST;
      bev_r <= `PEC_BEV_RST;
    end else if (st_we) begin
      mask_r <= reg_req.wdata[`PEC_ST_MASK_LSB +: 8];
      bev_r <= reg_req.wdata[`PEC_ST_BEV];
    end
  end

  // Sticky flags, cleared by writing zero; a new event wins the clear.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      parity_r <= 1'b0;
      wbe_r <= 1'b0;
    end else begin
      parity_r <= cache_parity_err |
                  (parity_r & ~(st_we & ~reg_req.wdata[`PEC_ST_PE]));
      wbe_r <= bus_err_wr |
               (wbe_r & ~(st_we & ~reg_req.wdata[`PEC_ST_WBE]));
    end
  end

  // Only the resume address is captured on entry.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      epc_r <= 32'h0000_0000;
    end else if (t_exc || t_int) begin
      epc_r <= ret_pc;
    end else if (epc_we) begin
      epc_r <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      errpc_r <= 32'h0000_0000;
    end else if (t_err || t_cache) begin
      errpc_r <= ret_pc;
    end else if (errpc_we) begin
      errpc_r <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bd_r <= 1'b0;
      code_r <= PEC_C_INT;
    end else if (take) begin
      bd_r <= c.bd & (t_exc | t_int);
      if (t_err) begin
        code_r <= PEC_C_NMI;
      end else if (t_cache) begin
        code_r <= PEC_C_CACHE;
      end else if (t_exc) begin
        code_r <= c.code;
      end else begin
        code_r <= PEC_C_INT;
      end
    end
  end

  always_comb begin
    st_val = '0;
    st_val[5:0] = stack_r;
    st_val[`PEC_ST_MASK_LSB +: 8] = mask_r;
    st_val[`PEC_ST_PE] = parity_r;
    st_val[`PEC_ST_BEV] = bev_r;
    st_val[`PEC_ST_WBE] = wbe_r;
    ca_val = '0;
    ca_val[`PEC_CA_CODE_LSB +: 5] = code_r;
    ca_val[`PEC_CA_PEND_LSB +: 8] = pend;
    ca_val[`PEC_CA_BD] = bd_r;
  end

  // Read data stand one cycle after the read strobe; others read zero.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_req.re) begin
      case (reg_req.addr)
        `PEC_OFF_STATUS: reg_rdata <= st_val;
        `PEC_OFF_CAUSE: reg_rdata <= ca_val;
        `PEC_OFF_EPC: reg_rdata <= epc_r;
        `PEC_OFF_ERRPC: reg_rdata <= errpc_r;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_exc_plain;
    t_exc && !c.bd;
  endsequence

  sequence s_exc_slot;
    t_exc && c.bd;
  endsequence

  sequence s_old_return;
    t_rfe && !take;
  endsequence

  a_redirect_vector: assert property (take |=> redirect &&
    redirect_pc == $past(vec)) else $error("late or wrong redirect");
  a_general_vector: assert property (t_exc && !c.refill && !bev_r
    |=> redirect_pc == 32'h8000_0180) else $error("bad general vector");
  a_epc_fault_pc: assert property (s_exc_plain |=>
    epc_r == $past(c.pc) && !bd_r) else $error("return pc wrong");
  a_epc_delay_slot: assert property (s_exc_slot |=>
    epc_r == $past(c.pc) - 32'h4 && bd_r) else $error("delay slot pc");
  a_int_masked: assert property (commit && !c.exc && no_err &&
    !stack_r[0] && !c.eret |=> !redirect) else $error("masked int taken");
  a_write_berr: assert property (bus_err_wr && !kill |=>
    !redirect && wbe_r) else $error("write bus error trapped");
  a_parity_flag: assert property (cache_parity_err && !kill |=>
    parity_r && !redirect) else $error("parity handling wrong");
  a_stack_push: assert property (take |=> stack_r ==
    {$past(stack_r[3:0]), 2'b00}) else $error("mode stack not pushed");
  a_young_killed: assert property (kill |=> !slot_q[0].valid &&
    !slot_q[3].valid ##1 !retire) else $error("younger not nullified");
  a_old_return: assert property (s_old_return |=> !redirect &&
    stack_r[3:0] == $past(stack_r[5:2])) else $error("old return flow");
  a_new_return: assert property (t_eret |=> redirect &&
    redirect_pc == $past(epc_r)) else $error("new return target");
  a_error_pc: assert property (t_err |=> errpc_r == $past(ret_pc)
    && redirect_pc == 32'hbfc0_0000) else $error("error pc wrong");
endmodule
`default_nettype wire

// ==== pec_pipe_model.sv ====
// Pipeline fetch model that feeds instructions and faults to the block.
`timescale 1ns/1ps
`default_nettype none
module pec_pipe_model #(
  parameter logic [31:0] START_PC = 32'h0000_1000
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Bench control.
  input wire logic slow,
  input wire logic [31:0] ds_pc,
  input wire logic [31:0] inj_pc [2],
  input wire logic [1:0] inj_stg [2],
  input wire pec_pkg::pec_event_t inj_ev [2],
  // Redirect from the block.
  input wire logic redirect,
  input wire logic [31:0] redirect_pc,
  // Fetch and faults to the block.
  output logic pipe_adv,
  output logic if_valid,
  output logic [31:0] if_pc,
  output logic if_in_delay_slot,
  output pec_pkg::pec_event_t stage_ev [4]
);
  import pec_pkg::*;
  logic [31:0] pc_r;
  logic [31:0] sh_r [3];
  logic [2:0] shv_r;
  logic tog_r;
  logic [31:0] ent_pc [4];
  logic [3:0] ent_v;
  assign pipe_adv = !(slow && tog_r);
  assign if_valid = !rst;
  assign if_pc = redirect ? redirect_pc : pc_r;
  assign if_in_delay_slot = (if_pc == ds_pc);
  assign ent_pc = '{if_pc, sh_r[0], sh_r[1], sh_r[2]};
  assign ent_v = {shv_r, 1'b1};
  // Faults are raised as the chosen instruction enters the chosen stage.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      stage_ev[k] = '0;
      for (int j = 0; j < 2; j++) begin
        if (inj_stg[j] == k[1:0] && ent_v[k] &&
            ent_pc[k] == inj_pc[j]) begin
          stage_ev[k] = stage_ev[k] | inj_ev[j];
        end
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    tog_r <= !tog_r && !rst;
    if (rst) begin
      pc_r <= START_PC;
      shv_r <= 3'h0;
    end else if (pipe_adv) begin
      pc_r <= if_pc + 32'h4;
      sh_r <= '{if_pc, sh_r[0], sh_r[1]};
      shv_r <= {redirect ? 2'h0 : shv_r[1:0], 1'b1};
    end else if (redirect) begin
      pc_r <= redirect_pc;
      shv_r <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the precise exception control block.
`timescale 1ns/1ps
`default_nettype none
`include "pec_defs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
  import pec_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] ext_int = 8'h00;
  logic fpu_exc = 1'b0;
  logic [2:0] pulse = 3'h0;
  logic par_err = 1'b0;
  logic wr_err = 1'b0;
  pec_reg_req_t reg_req = '0;
  logic [31:0] reg_rdata, redirect_pc, retire_pc, if_pc, tgt;
  logic redirect, retire, user_mode, int_enable;
  logic pipe_adv, if_valid, if_in_delay_slot;
  logic slow = 1'b0;
  logic [31:0] ds_pc = 32'h0;
  logic [31:0] inj_pc [2] = '{default: '0};
  logic [1:0] inj_stg [2] = '{default: '0};
  pec_event_t inj_ev [2] = '{default: '0};
  pec_event_t stage_ev [4];
  int num_errors = 0;
  int checked = 0;
  initial begin
    forever #2.5 clk_sys = !clk_sys;
  end
  pec_pipe_model u_pec_pipe_model (.clk_sys(clk_sys), .rst(rst),
    .slow(slow), .ds_pc(ds_pc), .inj_pc(inj_pc), .inj_stg(inj_stg),
    .inj_ev(inj_ev), .redirect(redirect), .redirect_pc(redirect_pc),
    .pipe_adv(pipe_adv), .if_valid(if_valid), .if_pc(if_pc),
    .if_in_delay_slot(if_in_delay_slot), .stage_ev(stage_ev));
  pec_precise_exc_ctrl u_pec_precise_exc_ctrl (.clk_sys(clk_sys),
    .rst(rst), .pipe_adv(pipe_adv), .if_valid(if_valid), .if_pc(if_pc),
    .if_in_delay_slot(if_in_delay_slot), .stage_ev(stage_ev),
    .ext_int(ext_int), .fpu_exc(fpu_exc), .nmi(pulse[1]),
    .soft_reset(pulse[2]), .cache_err(pulse[0]),
    .cache_parity_err(par_err), .bus_err_wr(wr_err), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .redirect(redirect), .redirect_pc(redirect_pc),
    .retire(retire), .retire_pc(retire_pc), .user_mode(user_mode),
    .int_enable(int_enable));
  task report_and_stop;
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.we <= 1'b1;
    @(posedge clk_sys);
    reg_req.we <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    reg_req.addr <= a;
    reg_req.re <= 1'b1;
    @(posedge clk_sys);
    reg_req.re <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
  task wt(input int n, input logic ret, output logic got);
    got = 1'b0;
    for (int i = 0; i < n && !got; i++) begin
      @(posedge clk_sys);
      got = ret ? (retire === 1'b1 && retire_pc === tgt) : redirect === 1'b1;
    end
  endtask
  task exc(input int s, input pec_event_t e, input pec_event_t y,
           input logic [4:0] code, input logic [31:0] vec, input logic ds);
    logic [31:0] st, v;
    logic got;
    rd(`PEC_OFF_STATUS, st);
    tgt = if_pc + 32'h20;
    ds_pc <= ds ? tgt : 32'h0;
    inj_pc <= '{tgt, tgt + 32'h4};
    inj_stg <= '{s[1:0], 2'h0};
    inj_ev <= '{e, y};
    wt(60, 1'b0, got);
    inj_ev <= '{default: '0};
    `CHK(got, 1'b1)
    `CHK(redirect_pc, vec)
    rd(`PEC_OFF_EPC, v);
    `CHK(v, ds ? tgt - 32'h4 : tgt)
    rd(`PEC_OFF_CAUSE, v);
    `CHK({v[31], v[6:2]}, {ds, code})
    rd(`PEC_OFF_STATUS, v);
    `CHK(v[5:0], {st[3:0], 2'h0})
  endtask
  task retn(input logic r, input logic [31:0] stv, input logic [5:0] want);
    logic [31:0] ep, v;
    logic got;
    pec_event_t e;
    e = '0;
    e.eret = r;
    e.rfe = !r;
    wr(`PEC_OFF_STATUS, stv);
    rd(`PEC_OFF_EPC, ep);
    tgt = if_pc + 32'h20;
    inj_pc[0] <= tgt;
    inj_stg[0] <= 2'h1;
    inj_ev[0] <= e;
    wt(60, !r, got);
    inj_ev[0] <= '0;
    `CHK(got, 1'b1)
    if (r) `CHK(redirect_pc, ep)
    rd(`PEC_OFF_STATUS, v);
    `CHK(v[5:0], want)
    `CHK({user_mode, int_enable}, want[1:0])
  endtask
  initial begin
    #100000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    logic [31:0] v, ep;
    logic got;
    pec_event_t e;
    static int fb [15] = '{16, 15, 14, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2,
      14};
    static logic [4:0] fc [15] = '{5'h04, 5'h05, 5'h02, 5'h03, 5'h01, 5'h0e,
      5'h17, 5'h07, 5'h0a, 5'h0b, 5'h08, 5'h09, 5'h0d, 5'h0c, 5'h02};
    static logic [31:0] rv [5] = '{32'h0040_0000, 32'h0, 32'h0, 32'h0,
      32'h0};
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    wr(8'h10, 32'hffff_ffff);
    wr(`PEC_OFF_CAUSE, 32'hffff_ffff);
    for (int i = 0; i < 5; i++) begin
      rd(8'(4 * i), v);
      `CHK(v, rv[i])
    end
    `CHK({user_mode, int_enable}, 2'h0)
    $display("test reset done");
    wr(`PEC_OFF_STATUS, 32'h0);
    for (int i = 0; i < 15; i++) begin
      e = '0;
      e[fb[i]] = 1'b1;
      e.tlb_refill = (i == 14);
      slow <= i[0];
      exc(i % 4, e, '0, fc[i], i == 14 ? `PEC_VEC_REFILL : `PEC_VEC_GEN,
          i == 5);
    end
    $display("test causes done");
    e = '0;
    e.bus_err_rd = 1'b1;
    exc(3, e, 17'h04000, 5'h07, `PEC_VEC_GEN, 1'b0);
    $display("test order done");
    wr(`PEC_OFF_STATUS, 32'h0000_0001);
    ext_int <= 8'h04;
    fpu_exc <= 1'b1;
    wt(12, 1'b0, got);
    `CHK(got, 1'b0)
    rd(`PEC_OFF_CAUSE, v);
    `CHK(v[15:8], 8'h0c)
    fpu_exc <= 1'b0;
    wr(`PEC_OFF_STATUS, 32'h0000_0401);
    wt(60, 1'b0, got);
    ext_int <= 8'h00;
    `CHK({got, redirect_pc}, {1'b1, `PEC_VEC_GEN})
    rd(`PEC_OFF_CAUSE, v);
    `CHK(v[6:2], 5'h00)
    `CHK(int_enable, 1'b0)
    $display("test interrupt done");
    par_err <= 1'b1;
    wr_err <= 1'b1;
    @(posedge clk_sys);
    par_err <= 1'b0;
    wr_err <= 1'b0;
    wt(12, 1'b0, got);
    `CHK(got, 1'b0)
    rd(`PEC_OFF_STATUS, v);
    `CHK({v[23], v[16]}, 2'h3)
    $display("test silent errors done");
    retn(1'b1, 32'h0000_0008, 6'h02);
    retn(1'b0, 32'h0000_0014, 6'h15);
    $display("test returns done");
    for (int j = 0; j < 3; j++) begin
      rd(`PEC_OFF_EPC, ep);
      tgt = u_pec_pipe_model.sh_r[1];
      pulse <= 3'h1 << j;
      @(posedge clk_sys);
      pulse <= 3'h0;
      wt(60, 1'b0, got);
      `CHK({got, redirect_pc}, {1'b1, j == 0 ? `PEC_VEC_CERR :
           `PEC_VEC_RESET})
      rd(`PEC_OFF_CAUSE, v);
      `CHK(v[6:2], j == 0 ? 5'h1e : 5'h1f)
      rd(`PEC_OFF_EPC, v);
      `CHK(v, ep)
      rd(`PEC_OFF_ERRPC, v);
      `CHK(v, tgt)
    end
    $display("test error class done");
    report_and_stop;
  end
endmodule
`default_nettype wire
